// ===== pkg/tsc_defs.svh
// register offsets, field positions, reset values and timing of the sleep timer
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
`define TSC_OFS_FLAGS 10'h031
`define TSC_OFS_ACK_WCL 10'h035
`define TSC_OFS_WCH 10'h036
`define TSC_OFS_SRC_SEL 10'h207
`define TSC_OFS_CAL0 10'h209
`define TSC_OFS_CAL1 10'h20a
`define TSC_OFS_CAL2 10'h20b
`define TSC_OFS_OSC_CTL 10'h211
`define TSC_OFS_DIV 10'h220
`define TSC_OFS_WT_LO 10'h222
`define TSC_OFS_WT_HI 10'h223
`define TSC_OFS_REM_LO 10'h224
`define TSC_OFS_REM_HI 10'h225
`define TSC_OFS_MAIN0 10'h226
`define TSC_OFS_MAIN1 10'h227
`define TSC_OFS_MAIN2 10'h228
`define TSC_OFS_MAIN3 10'h229
`define TSC_BIT_DOZE_FLAG 7
`define TSC_BIT_WAKE_FLAG 6
`define TSC_BIT_ACK 7
`define TSC_BIT_CAL_DONE 7
`define TSC_BIT_CAL_GO 4
`define TSC_BIT_COUNT_GO 7
`define TSC_SRC_INTERNAL 2'h2
`define TSC_SRC_EXTERNAL 2'h1
`define TSC_RST_BYTE 8'h00
`define TSC_RST_SRC 2'h2
`define TSC_CAL_PERIODS 5'h10
`define TSC_MCLK_MHZ 40
`define TSC_FINE_STEP_NS 50
`define TSC_FINE_STEP_CYC ((`TSC_FINE_STEP_NS * `TSC_MCLK_MHZ) / 1000)
`endif

// ===== pkg/tsc_pkg.sv
// types shared by the timed sleep controller modules
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_MODE_OFF,
    TSC_MODE_COORD,
    TSC_MODE_DEVICE,
    TSC_MODE_NONBEACON
  } tsc_mode_t;
  typedef enum {
    ST_IDLE,
    ST_ALERT,
    ST_DOZE,
    ST_SETTLE,
    ST_AWAKE_RUN,
    ST_REMAIN
  } tsc_state_t;
endpackage

// ===== pkg/tsc_tick_if.sv
// carrier between the top and the sleep clock divider
`timescale 1ns/1ps
interface tsc_tick_if;
  logic raw_tick; // one pulse per selected oscillator period
  logic [4:0] divisor; // power-of-two division exponent
  logic div_tick; // one pulse per divided period
  modport src (output raw_tick, output divisor, input div_tick);
  modport div (input raw_tick, input divisor, output div_tick);
endinterface

// ===== hw/tsc_divider.sv
// sleep clock divider: one output pulse per 2**divisor input pulses
`timescale 1ns/1ps
module tsc_divider (
  input wire logic mclk,
  input wire logic reset,
  tsc_tick_if.div tk
);
  import tsc_pkg::*;
  logic [31:0] cnt_q; // input pulses seen in this divided period
  logic [31:0] cnt_d;
  logic [31:0] last_w; // terminal count for the current divisor
  logic wrap_w;
  assign last_w = (32'h1 << tk.divisor) - 32'h1;
  assign wrap_w = tk.raw_tick && (cnt_q >= last_w);
  assign cnt_d = wrap_w ? 32'h0 : (tk.raw_tick ? cnt_q + 32'h1 : cnt_q);
  assign tk.div_tick = wrap_w;
  // count is compared with >= so a divisor lowered mid-period still wraps
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ===== hw/tsc_top.sv
// timed sleep controller: sleep clock, calibration, sleep counters, alerts
`timescale 1ns/1ps
`include "tsc_defs.svh"
// Summary of operation
// - stop main oscillator while asleep
// - registers retained, port reachable in sleep
// - source select picks internal or external
// - oscillator disable bit, active low enable
// - divisor further divides selected sleep clock
// - calibration counts fine steps, sixteen periods
// - calibration done flag when count completes
// - calibration result readable in three bytes
// - calibration counts in 50 ns steps
// - 26-bit main counter on sleep clock
// - 16-bit remain counter on main clock
// - wake time match restarts main oscillator
// - wake counter gates core clock while settling
// - coordinator beacon once per interval
// - device times inactive period
// - sleep alert at active/inactive boundary
// - acknowledge write turns main oscillator off
// - wake alert after settle count ends
// - nonbeacon start bit, wake alert at end
// - nonbeacon remain counts at half weight
module tsc_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic osc_int_in,
  input wire logic osc_ext_in,
  input wire tsc_pkg::tsc_mode_t sleep_mode,
  output logic main_osc_en,
  output logic core_clk_en,
  output logic low_power_tick,
  output logic beacon_tx,
  output logic inactive_end,
  output logic doze_alert_flag,
  output logic wake_alert_flag
);
  import tsc_pkg::*;

  // host-written configuration, kept through sleep
  logic [1:0] low_power_source_sel_q;
  logic low_power_osc_disable_n_q; // 1 stops the sleep oscillators
  logic [4:0] low_power_divisor_q;
  logic [10:0] osc_restart_point_q;
  logic [8:0] osc_settle_count_q;
  logic [15:0] fine_interval_count_q;
  logic [25:0] long_interval_count_q;
  // status
  logic period_measure_done_q;
  logic [19:0] period_measure_result_q;
  logic doze_flag_q;
  logic wake_flag_q;
  // sequencer
  tsc_state_t st_q;
  tsc_state_t st_d;
  logic [25:0] main_cnt_q; // counts down in sleep ticks
  logic [15:0] rem_cnt_q; // counts down in fine steps, every mclk in nonbeacon
  logic [8:0] settle_cnt_q;
  // calibration engine
  logic cal_busy_q;
  logic cal_armed_q; // first tick seen, measuring
  logic [4:0] cal_per_q;
  logic [19:0] cal_acc_q;
  // oscillator pin synchronisers and edge detect
  logic [1:0] int_sync_q;
  logic [1:0] ext_sync_q;
  logic sel_last_q;
  logic [1:0] fast_cnt_q; // half-rate step generator
  logic [7:0] rdata_q;
  logic beacon_q;
  logic inact_q;

  tsc_tick_if tk ();

  // register write decode
  // writes to the flag register are ignored: only a read clears the flags
  wire wr_ack = reg_wr && (reg_addr == `TSC_OFS_ACK_WCL);
  wire wr_wch = reg_wr && (reg_addr == `TSC_OFS_WCH);
  wire wr_src = reg_wr && (reg_addr == `TSC_OFS_SRC_SEL);
  wire wr_cal2 = reg_wr && (reg_addr == `TSC_OFS_CAL2);
  wire wr_osc = reg_wr && (reg_addr == `TSC_OFS_OSC_CTL);
  wire wr_div = reg_wr && (reg_addr == `TSC_OFS_DIV);
  wire wr_wtl = reg_wr && (reg_addr == `TSC_OFS_WT_LO);
  wire wr_wth = reg_wr && (reg_addr == `TSC_OFS_WT_HI);
  wire wr_rml = reg_wr && (reg_addr == `TSC_OFS_REM_LO);
  wire wr_rmh = reg_wr && (reg_addr == `TSC_OFS_REM_HI);
  wire wr_m0 = reg_wr && (reg_addr == `TSC_OFS_MAIN0);
  wire wr_m1 = reg_wr && (reg_addr == `TSC_OFS_MAIN1);
  wire wr_m2 = reg_wr && (reg_addr == `TSC_OFS_MAIN2);
  wire wr_m3 = reg_wr && (reg_addr == `TSC_OFS_MAIN3);
  wire rd_flags = reg_rd && (reg_addr == `TSC_OFS_FLAGS);
  wire doze_ack = wr_ack && reg_wdata[`TSC_BIT_ACK];
  wire cal_go = wr_cal2 && reg_wdata[`TSC_BIT_CAL_GO];
  wire count_go = wr_m3 && reg_wdata[`TSC_BIT_COUNT_GO];

  // sleep clock source and gating
  wire sel_level = (low_power_source_sel_q == `TSC_SRC_INTERNAL) ?
                   int_sync_q[1] :
                   (low_power_source_sel_q == `TSC_SRC_EXTERNAL) ?
                   ext_sync_q[1] : 1'b0;
  wire raw_edge = sel_level && !sel_last_q;
  assign tk.raw_tick = raw_edge && !low_power_osc_disable_n_q;
  assign tk.divisor = low_power_divisor_q;
  wire slp_tick = tk.div_tick;
  assign low_power_tick = slp_tick;

  // one fine step per 50 ns of main clock
  wire fast_step = (fast_cnt_q == 2'(`TSC_FINE_STEP_CYC - 1));
  wire is_beacon = (sleep_mode == TSC_MODE_COORD) ||
                   (sleep_mode == TSC_MODE_DEVICE);
  wire is_nonbeacon = (sleep_mode == TSC_MODE_NONBEACON);
  // nonbeacon remain runs at every mclk: half weight of the fine step
  wire rem_step = is_nonbeacon ? 1'b1 : fast_step;
  wire main_zero = (main_cnt_q == 26'h0);
  wire at_wake = (main_cnt_q <= {15'h0, osc_restart_point_q});
  wire settled = (settle_cnt_q >= osc_settle_count_q);
  wire rem_zero = (rem_cnt_q == 16'h0);
  wire alert_set = (st_q == ST_IDLE && is_beacon) ||
                   (st_q == ST_REMAIN && rem_zero && is_beacon);
  wire wake_set = (st_q == ST_SETTLE && settled && is_beacon) ||
                  (st_q == ST_REMAIN && rem_zero && is_nonbeacon);
  wire cal_end = cal_armed_q && slp_tick &&
                 (cal_per_q == `TSC_CAL_PERIODS - 5'h1);

  tsc_divider u_div (
    .mclk(mclk),
    .reset(reset),
    .tk(tk)
  );

  // sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (is_beacon) begin
          st_d = ST_ALERT;
        end else if (is_nonbeacon && count_go) begin
          st_d = ST_DOZE;
        end
      end
      ST_ALERT: begin
        if (sleep_mode == TSC_MODE_OFF) begin
          st_d = ST_IDLE;
        end else if (doze_ack) begin
          st_d = ST_DOZE;
        end
      end
      ST_DOZE: begin
        if (slp_tick && at_wake) begin
          st_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settled) begin
          st_d = ST_AWAKE_RUN;
        end
      end
      ST_AWAKE_RUN: begin
        if (main_zero) begin
          st_d = ST_REMAIN;
        end
      end
      ST_REMAIN: begin
        if (rem_zero) begin
          st_d = is_beacon ? ST_ALERT : ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // oscillator and core gating follow the sequencer
  assign main_osc_en = (st_q != ST_DOZE);
  assign core_clk_en = (st_q != ST_DOZE) && (st_q != ST_SETTLE);
  assign doze_alert_flag = doze_flag_q;
  assign wake_alert_flag = wake_flag_q;
  assign beacon_tx = beacon_q;
  assign inactive_end = inact_q;
  assign reg_rdata = rdata_q;

  // sequencer state and counters
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      main_cnt_q <= 26'h0;
      rem_cnt_q <= 16'h0;
      settle_cnt_q <= 9'h0;
    end else begin
      st_q <= st_d;
      if (st_q != ST_DOZE && st_d == ST_DOZE) begin
        main_cnt_q <= long_interval_count_q;
      end else if (slp_tick && !main_zero) begin
        main_cnt_q <= main_cnt_q - 26'h1;
      end
      if (st_d == ST_SETTLE && st_q != ST_SETTLE) begin
        settle_cnt_q <= 9'h0;
      end else if (st_q == ST_SETTLE && slp_tick && !settled) begin
        settle_cnt_q <= settle_cnt_q + 9'h1;
      end
      if (st_d == ST_REMAIN && st_q != ST_REMAIN) begin
        rem_cnt_q <= fine_interval_count_q;
      end else if (st_q == ST_REMAIN && rem_step && !rem_zero) begin
        rem_cnt_q <= rem_cnt_q - 16'h1;
      end
    end
  end

  // interval end pulses per beacon role
  always_ff @(posedge mclk) begin
    if (reset) begin
      beacon_q <= 1'b0;
      inact_q <= 1'b0;
    end else begin
      beacon_q <= (st_q == ST_REMAIN) && rem_zero &&
                  (sleep_mode == TSC_MODE_COORD);
      inact_q <= (st_q == ST_REMAIN) && rem_zero &&
                 (sleep_mode == TSC_MODE_DEVICE);
    end
  end

  // alert flags: set wins over the read that clears them
  always_ff @(posedge mclk) begin
    if (reset) begin
      doze_flag_q <= 1'b0;
      wake_flag_q <= 1'b0;
    end else begin
      doze_flag_q <= alert_set || (doze_flag_q && !rd_flags);
      wake_flag_q <= wake_set || (wake_flag_q && !rd_flags);
    end
  end

  // pins pass two flops before the edge detector looks at them
  always_ff @(posedge mclk) begin
    if (reset) begin
      int_sync_q <= 2'h0;
      ext_sync_q <= 2'h0;
      // starts high, but the synchronisers reset low, so a pin already high at release still gives one tick two cycles later
      sel_last_q <= 1'b1;
      fast_cnt_q <= 2'h0;
    end else begin
      int_sync_q <= {int_sync_q[0], osc_int_in};
      ext_sync_q <= {ext_sync_q[0], osc_ext_in};
      sel_last_q <= sel_level;
      fast_cnt_q <= fast_step ? 2'h0 : fast_cnt_q + 2'h1;
    end
  end

  // calibration: wait for a tick, then count steps over sixteen periods
  always_ff @(posedge mclk) begin
    if (reset) begin
      cal_busy_q <= 1'b0;
      cal_armed_q <= 1'b0;
      cal_per_q <= 5'h0;
      cal_acc_q <= 20'h0;
      period_measure_done_q <= 1'b0;
      period_measure_result_q <= 20'h0;
    end else if (cal_go) begin
      cal_busy_q <= 1'b1;
      cal_armed_q <= 1'b0;
      cal_per_q <= 5'h0;
      cal_acc_q <= 20'h0;
      period_measure_done_q <= 1'b0;
    end else if (cal_busy_q) begin
      if (!cal_armed_q) begin
        cal_armed_q <= slp_tick;
      end else begin
        if (fast_step) begin
          cal_acc_q <= cal_acc_q + 20'h1;
        end
        if (slp_tick) begin
          cal_per_q <= cal_per_q + 5'h1;
        end
        if (cal_end) begin
          cal_busy_q <= 1'b0;
          period_measure_done_q <= 1'b1;
          period_measure_result_q <= cal_acc_q +
                                     {19'h0, fast_step};
        end
      end
    end
  end

  // configuration writes; the port answers whatever the sleep state
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_power_source_sel_q <= `TSC_RST_SRC;
      low_power_osc_disable_n_q <= 1'b0;
      low_power_divisor_q <= 5'h0;
      osc_restart_point_q <= 11'h0;
      osc_settle_count_q <= 9'h0;
      fine_interval_count_q <= 16'h0;
      long_interval_count_q <= 26'h0;
    end else begin
      if (wr_src) low_power_source_sel_q <= reg_wdata[7:6];
      if (wr_osc) low_power_osc_disable_n_q <= reg_wdata[0];
      if (wr_div) low_power_divisor_q <= reg_wdata[4:0];
      if (wr_wtl) osc_restart_point_q[7:0] <= reg_wdata;
      if (wr_wth) osc_restart_point_q[10:8] <= reg_wdata[2:0];
      if (wr_ack) osc_settle_count_q[6:0] <= reg_wdata[6:0];
      if (wr_wch) osc_settle_count_q[8:7] <= reg_wdata[4:3];
      if (wr_rml) fine_interval_count_q[7:0] <= reg_wdata;
      if (wr_rmh) fine_interval_count_q[15:8] <= reg_wdata;
      if (wr_m0) long_interval_count_q[7:0] <= reg_wdata;
      if (wr_m1) long_interval_count_q[15:8] <= reg_wdata;
      if (wr_m2) long_interval_count_q[23:16] <= reg_wdata;
      if (wr_m3) long_interval_count_q[25:24] <= reg_wdata[1:0];
    end
  end

  // read data selection; ack and start bits read back as 0 / busy
  wire [7:0] rd_flags_w = {doze_flag_q, wake_flag_q, 6'h0};
  wire [7:0] rd_cal2_w = {period_measure_done_q, 2'h0, 1'b0,
                          period_measure_result_q[19:16]};
  wire [7:0] rd_main3_w = {(st_q == ST_DOZE), 5'h0,
                           long_interval_count_q[25:24]};
  wire [7:0] rd_mux =
    (reg_addr == `TSC_OFS_FLAGS) ? rd_flags_w :
    (reg_addr == `TSC_OFS_ACK_WCL) ? {1'b0, osc_settle_count_q[6:0]} :
    (reg_addr == `TSC_OFS_WCH) ? {3'h0, osc_settle_count_q[8:7], 3'h0} :
    (reg_addr == `TSC_OFS_SRC_SEL) ? {low_power_source_sel_q, 6'h0} :
    (reg_addr == `TSC_OFS_CAL0) ? period_measure_result_q[7:0] :
    (reg_addr == `TSC_OFS_CAL1) ? period_measure_result_q[15:8] :
    (reg_addr == `TSC_OFS_CAL2) ? rd_cal2_w :
    (reg_addr == `TSC_OFS_OSC_CTL) ? {7'h0, low_power_osc_disable_n_q} :
    (reg_addr == `TSC_OFS_DIV) ? {3'h0, low_power_divisor_q} :
    (reg_addr == `TSC_OFS_WT_LO) ? osc_restart_point_q[7:0] :
    (reg_addr == `TSC_OFS_WT_HI) ? {5'h0, osc_restart_point_q[10:8]} :
    (reg_addr == `TSC_OFS_REM_LO) ? fine_interval_count_q[7:0] :
    (reg_addr == `TSC_OFS_REM_HI) ? fine_interval_count_q[15:8] :
    (reg_addr == `TSC_OFS_MAIN0) ? long_interval_count_q[7:0] :
    (reg_addr == `TSC_OFS_MAIN1) ? long_interval_count_q[15:8] :
    (reg_addr == `TSC_OFS_MAIN2) ? long_interval_count_q[23:16] :
    (reg_addr == `TSC_OFS_MAIN3) ? rd_main3_w : `TSC_RST_BYTE;

  // read data is registered: valid the cycle after reg_rd
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= `TSC_RST_BYTE;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // checks on the sequencer, flags and calibration
  sequence seq_ack_write;
    st_q == ST_ALERT && doze_ack && sleep_mode != TSC_MODE_OFF;
  endsequence
  sequence seq_dozing;
    st_q == ST_DOZE && !main_osc_en && !core_clk_en;
  endsequence

  a_ack_sleeps: assert property (@(posedge mclk) disable iff (reset)
    seq_ack_write |=> seq_dozing)
    else $error("ack did not stop the main oscillator");
  a_doze_osc_off: assert property (@(posedge mclk) disable iff (reset)
    st_q == ST_DOZE |-> !main_osc_en)
    else $error("main oscillator running while asleep");
  a_wake_restart: assert property (@(posedge mclk) disable iff (reset)
    (st_q == ST_DOZE && slp_tick && at_wake) |=>
    (main_osc_en && !core_clk_en))
    else $error("wake match did not restart oscillator");
  a_settle_gate: assert property (@(posedge mclk) disable iff (reset)
    (st_q == ST_SETTLE && !settled) |=> !core_clk_en)
    else $error("core clock enabled before settle count");
  a_flag_pending: assert property (@(posedge mclk) disable iff (reset)
    (doze_flag_q && !rd_flags) |=> doze_flag_q)
    else $error("sleep alert dropped without read");
  a_wake_alert: assert property (@(posedge mclk) disable iff (reset)
    (st_q == ST_SETTLE && settled && is_beacon) |=> wake_flag_q)
    else $error("wake alert missing after settle");
  a_cal_restart: assert property (@(posedge mclk) disable iff (reset)
    cal_go |=> (!period_measure_done_q && cal_busy_q))
    else $error("calibration start did not clear done");
  a_cal_stable: assert property (@(posedge mclk) disable iff (reset)
    (period_measure_done_q && !cal_go) |=>
    $stable(period_measure_result_q))
    else $error("calibration result changed while done");
  a_nb_start: assert property (@(posedge mclk) disable iff (reset)
    (st_q == ST_IDLE && is_nonbeacon && count_go) |=> ##[0:1] seq_dozing)
    else $error("start bit did not begin sleep");
endmodule

// ===== test/tsc_host_model.sv
// host side model: register port driver and the two sleep oscillators
`timescale 1ns/1ps
module tsc_host_model (
  input wire logic mclk,
  output logic [9:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic osc_int_in,
  output logic osc_ext_in
);
  // idle bus, address parked on an unmapped place
  initial begin
    reg_addr = 10'h3ff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    osc_int_in = 1'b0;
    osc_ext_in = 1'b0;
  end
  // oscillators run free; periods shortened so the run stays brief
  always #500 osc_int_in = ~osc_int_in;
  always #1000 osc_ext_in = ~osc_ext_in;
  // one write strobe; usable in any state, asleep included
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // data no longer held, so show a stale inverse
  endtask
  // one read strobe; data is registered, so take it an edge later
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask
endmodule

// ===== test/test_tsc_top.sv
// self-checking bench for the timed sleep controller
`timescale 1ns/1ps
`include "tsc_defs.svh"
module test_tsc_top;
  import tsc_pkg::*;
  logic mclk = 1'b0; // 40 MHz
  logic reset = 1'b1; // synchronous, active high
  tsc_mode_t sleep_mode = TSC_MODE_OFF; // beacon mode select
  wire [9:0] reg_addr;
  wire reg_wr;
  wire reg_rd;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire osc_int_in;
  wire osc_ext_in;
  wire main_osc_en;
  wire core_clk_en;
  wire low_power_tick;
  wire beacon_tx;
  wire inactive_end;
  wire doze_alert_flag;
  wire wake_alert_flag;
  int n_errors = 0; // mismatches seen
  int num_checks = 0; // comparisons made
  int cyc = 0; // run length guard
  int g; // measured tick gap
  int n; // pulse counter
  // monitored outputs, by index: osc, core, doze, wake, beacon, inact, tick
  wire [6:0] mon = {low_power_tick, inactive_end, beacon_tx,
    wake_alert_flag, doze_alert_flag, core_clk_en, main_osc_en};

  always #12.5 mclk = ~mclk;

  tsc_top i_dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_int_in(osc_int_in), .osc_ext_in(osc_ext_in),
    .sleep_mode(sleep_mode), .main_osc_en(main_osc_en),
    .core_clk_en(core_clk_en), .low_power_tick(low_power_tick),
    .beacon_tx(beacon_tx), .inactive_end(inactive_end),
    .doze_alert_flag(doze_alert_flag), .wake_alert_flag(wake_alert_flag)
  );

  tsc_host_model i_host (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_int_in(osc_int_in), .osc_ext_in(osc_ext_in)
  );

  // closing report, the single end of the run
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // compare seen against expected, four-state exact
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // register read compared against a value
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    check(d, exp);
  endtask

  // write then read back the same place
  task automatic wrchk(input logic [9:0] a, input logic [7:0] d);
    i_host.wr(a, d);
    rchk(a, d);
  endtask

  // bounded wait for a monitored output to reach a level
  task automatic wait_bit(input int idx, input logic lvl, input int lim);
    int k;
    k = 0;
    while (mon[idx] !== lvl && k < lim) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check(mon[idx], lvl);
  endtask

  // cycles between two divided sleep ticks
  task automatic tick_gap(output int gap);
    wait_bit(6, 1'b1, 800);
    gap = 0;
    do begin
      @(posedge mclk);
      #1;
      gap++;
    end while (mon[6] !== 1'b1 && gap < 1000);
  endtask

  // one calibration; sync jitter allows two steps either way
  task automatic cal_run(input int e);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    int k;
    i_host.wr(`TSC_OFS_CAL2, 8'h10);
    i_host.rd(`TSC_OFS_CAL2, b2);
    check(b2[7], 1'b0);
    k = 0;
    while (b2[7] !== 1'b1 && k < 1000) begin
      i_host.rd(`TSC_OFS_CAL2, b2);
      k++;
    end
    check({b2[7], b2[6:4]}, 4'h8);
    i_host.rd(`TSC_OFS_CAL0, b0);
    i_host.rd(`TSC_OFS_CAL1, b1);
    check(20'({b2[3:0], b1, b0}) >= e - 2, 1);
    check(20'({b2[3:0], b1, b0}) <= e + 2, 1);
    rchk(`TSC_OFS_CAL0, b0);
  endtask

  // reset held 12 cycles, mode off so the sequencer idles
  task automatic do_reset();
    @(posedge mclk);
    sleep_mode <= TSC_MODE_OFF;
    reset <= 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
  endtask

  // short counts; a real host would use about 2 ms of settle time
  task automatic prog();
    i_host.wr(`TSC_OFS_MAIN0, 8'h04);
    i_host.wr(`TSC_OFS_WT_LO, 8'h02);
    i_host.wr(`TSC_OFS_REM_LO, 8'h0a);
    i_host.wr(`TSC_OFS_ACK_WCL, 8'h01);
  endtask

  // run length guard, well above the expected few thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    do_reset();
    // reset values, unmapped place, plain read/write
    rchk(`TSC_OFS_SRC_SEL, 8'h80);
    rchk(`TSC_OFS_OSC_CTL, 8'h00);
    rchk(`TSC_OFS_CAL2, 8'h00);
    rchk(`TSC_OFS_FLAGS, 8'h00);
    i_host.wr(10'h100, 8'h5a);
    rchk(10'h100, 8'h00);
    wrchk(`TSC_OFS_MAIN2, 8'ha5);
    wrchk(`TSC_OFS_MAIN3, 8'h03);
    wrchk(`TSC_OFS_REM_HI, 8'h5a);
    wrchk(`TSC_OFS_WT_HI, 8'h07);
    // tick spacing doubles with each divisor step
    for (int d = 0; d < 3; d++) begin
      wrchk(`TSC_OFS_DIV, 8'(d));
      tick_gap(g);
      tick_gap(g);
      check(20'(g), 20'(40 << d));
    end
    i_host.wr(`TSC_OFS_DIV, 8'h00);
    // oscillators disabled: no ticks, calibration never finishes
    i_host.wr(`TSC_OFS_OSC_CTL, 8'h01);
    i_host.wr(`TSC_OFS_CAL2, 8'h10);
    n = 0;
    repeat (1500) begin
      @(posedge mclk);
      #1;
      if (mon[6] === 1'b1)
        n++;
    end
    check(20'(n), 20'h0);
    rchk(`TSC_OFS_CAL2, 8'h00);
    i_host.wr(`TSC_OFS_OSC_CTL, 8'h00);
    cal_run(320);
    wrchk(`TSC_OFS_SRC_SEL, 8'h40);
    cal_run(640);
    // nonbeacon sleep started by the host
    do_reset();
    prog();
    @(posedge mclk);
    sleep_mode <= TSC_MODE_NONBEACON;
    i_host.wr(`TSC_OFS_MAIN3, 8'h80);
    wait_bit(0, 1'b0, 4);
    wait_bit(1, 1'b0, 1);
    rchk(`TSC_OFS_MAIN3, 8'h80);
    wait_bit(0, 1'b1, 400);
    check(mon[1], 1'b0);
    wait_bit(3, 1'b1, 400);
    check(mon[1:0], 2'h3);
    repeat (20) @(posedge mclk);
    #1;
    check(mon[3], 1'b1);
    rchk(`TSC_OFS_FLAGS, 8'h40);
    check(mon[3], 1'b0);
    // coordinator then device: alert, ack, sleep, wake, interval end
    for (int m = 1; m < 3; m++) begin
      do_reset();
      prog();
      @(posedge mclk);
      sleep_mode <= tsc_mode_t'(m);
      wait_bit(2, 1'b1, 8);
      rchk(`TSC_OFS_FLAGS, 8'h80);
      i_host.wr(`TSC_OFS_ACK_WCL, 8'h81);
      wait_bit(0, 1'b0, 4);
      rchk(`TSC_OFS_ACK_WCL, 8'h01);
      wait_bit(0, 1'b1, 400);
      check(mon[1], 1'b0);
      wait_bit(1, 1'b1, 400);
      wait_bit(3, 1'b1, 4);
      wait_bit(3 + m, 1'b1, 400);
      check(mon[6 - m], 1'b0);
      wait_bit(2, 1'b1, 3);
    end
    stop_test();
  end
endmodule
